// ---- frame_memory_model.sv ----
// Frame buffer memory answering the overlay pixel fetches.
// Assumes one-cycle request pulses.
`timescale 1ns/100ps
module frame_memory_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic req,
    input wire logic [31:0] addr,
    input wire logic [1:0] delay,
    output logic [31:0] rd_word,
    output logic rd_valid
);
    logic [31:0] addr_r;
    logic [1:0] wait_r;
    logic pend_r;
    // Data inverts each cycle without rd_valid, so a stale word reappears only every second cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pend_r <= 1'b0;
            rd_valid <= 1'b0;
            rd_word <= 32'h0;
        end else if (req) begin
            pend_r <= 1'b1;
            addr_r <= addr;
            wait_r <= delay;
            rd_valid <= 1'b0;
            rd_word <= ~rd_word;
        end else if (pend_r && wait_r == 2'h0) begin
            pend_r <= 1'b0;
            rd_valid <= 1'b1;
            rd_word <= addr_r ^ 32'h5A5A0000;
        end else begin
            wait_r <= wait_r - 2'h1;
            rd_valid <= 1'b0;
            rd_word <= ~rd_word;
        end
    end
endmodule

// ---- overlay_fmt_checker.sv ----
// Assertions on the overlay block ports, bound in.
// Assumes one aclk domain with a synchronous active-low reset.
`timescale 1ns/100ps
module overlay_fmt_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic frame_start,
    input wire logic [31:0] luma_base,
    input wire logic pixel_step,
    input wire logic [overlay_fmt_pkg::COORD_W-1:0] beam_x,
    input wire logic [overlay_fmt_pkg::COORD_W-1:0] beam_y,
    input wire logic fetched_valid,
    input wire overlay_fmt_pkg::pixel_kind_t pixel_kind,
    input wire overlay_fmt_pkg::geometry_t geometry,
    input wire overlay_fmt_pkg::fetch_pos_t fetch_pos,
    input wire logic fetch_busy,
    input wire logic in_window,
    input wire logic pixel_valid
);
    import overlay_fmt_pkg::*;
    logic [12:0] x_end, y_end;
    logic win_hit;
    // Wide sums so a window at the right edge cannot wrap
    assign x_end = geometry.x_start + geometry.width;
    assign y_end = geometry.y_start + geometry.height;
    assign win_hit = beam_x >= geometry.x_start && beam_x < x_end
        && beam_y >= geometry.y_start && beam_y < y_end;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("bresp dropped");
    a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read overlap");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read late");
    a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("write overlap");
    a_walk_start:
        assert property (frame_start |=> fetch_busy && fetch_pos.luma_addr == $past(luma_base)
            && fetch_pos.column == 0 && fetch_pos.row == 0) else $error("bad walk start");
    a_config_hold:
        assert property (!frame_start |=> $stable(pixel_kind) && $stable(geometry))
        else $error("mid-frame change");
    a_sizes_plus:
        assert property (geometry.width != 0 && geometry.height != 0
            && geometry.image_width != 0 && geometry.image_height != 0)
        else $error("zero size");
    a_window_hit:
        assert property (1'b1 |=> in_window == $past(win_hit)) else $error("bad window flag");
    a_pixel_follow: assert property (1'b1 |=> pixel_valid == $past(fetched_valid))
        else $error("pixel valid late");
    a_idle_step: assert property (pixel_step && !fetch_busy && !frame_start |=>
        $stable(fetch_pos)) else $error("idle step moved");
endmodule

bind video_overlay_format_geometry overlay_fmt_checker i_chk (.*);

// ---- overlay_fmt_pkg.sv ----
// Constants and carrier types for the overlay format and geometry block.
// Assumes a 32-bit AXI4-Lite register bus and a single 100 MHz clock.
package overlay_fmt_pkg;

    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;

    // Register byte addresses
    localparam logic [31:0] OFS_PIXEL_FORMAT = 32'hF80382D0;
    localparam logic [31:0] OFS_WINDOW_POS = 32'hF80382D4;
    localparam logic [31:0] OFS_WINDOW_SIZE = 32'hF80382D8;
    localparam logic [31:0] OFS_IMAGE_SIZE = 32'hF80382DC;
    localparam logic [31:0] OFS_ROW_STRIDE = 32'hF80382E0;
    localparam logic [31:0] OFS_PIXEL_STRIDE = 32'hF80382E4;
    localparam logic [31:0] OFS_CHROMA_STRIDE = 32'hF80382E8;
    localparam logic [31:0] OFS_STATUS = 32'hF8038400;

    // Writable bits; reserved bits read as zero
    localparam logic [31:0] MASK_PIXEL_FORMAT = 32'h0003F3F3;
    localparam logic [31:0] MASK_COORD_PAIR = 32'h07FF07FF;
    localparam logic [31:0] RESET_VALUE = 32'h00000000;

    // Pixel format and coordinate pair field positions
    localparam int POS_LUT_SEL = 0;
    localparam int POS_YUV_SEL = 1;
    localparam int POS_RGB_FMT = 4;
    localparam int POS_IDX_DEPTH = 8;
    localparam int POS_YUV_FMT = 12;
    localparam int POS_ROT = 16;
    localparam int POS_SWAP = 17;
    localparam int POS_X = 0;
    localparam int POS_Y = 16;
    localparam int COORD_W = 11;

    // Direct colour codes
    localparam logic [3:0] RGB_444_12 = 4'h0;
    localparam logic [3:0] RGB_666_18 = 4'h5;
    localparam logic [3:0] RGB_1666_19 = 4'h7;
    localparam logic [3:0] RGB_888_24 = 4'h9;
    localparam logic [3:0] RGB_1888_25 = 4'hB;
    localparam logic [3:0] RGB_LAST = 4'hD;

    // Luma and chroma codes
    localparam logic [3:0] YUV_AYCBCR_444 = 4'h0;
    localparam logic [3:0] YUV_PACKED_LAST = 4'h4;
    localparam logic [3:0] YUV_422_SEMI = 4'h5;
    localparam logic [3:0] YUV_422_PLANAR = 4'h6;
    localparam logic [3:0] YUV_420_SEMI = 4'h7;
    localparam logic [3:0] YUV_420_PLANAR = 4'h8;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        PLANES_ONE = 2'h0,
        PLANES_SEMI = 2'h1,
        PLANES_THREE = 2'h2
    } plane_mode_t;

    typedef enum logic [1:0] {
        FETCH_IDLE = 2'b00,
        FETCH_RUN = 2'b01,
        FETCH_DONE = 2'b11
    } fetch_state_t;

    typedef struct packed {
        logic is_index;
        logic is_yuv;
        logic [5:0] bits_per_pixel;
        logic packed_layout;
        logic has_alpha;
        plane_mode_t planes;
        logic chroma_half_rows;
        logic rotate_upsample;
        logic luma_swap;
        logic bad_code;
    } pixel_kind_t;

    typedef struct packed {
        logic [COORD_W-1:0] x_start;
        logic [COORD_W-1:0] y_start;
        logic [COORD_W:0] width;
        logic [COORD_W:0] height;
        logic [COORD_W:0] image_width;
        logic [COORD_W:0] image_height;
    } geometry_t;

    typedef struct packed {
        logic [31:0] luma_addr;
        logic [31:0] chroma_addr;
        logic [COORD_W:0] column;
        logic [COORD_W:0] row;
    } fetch_pos_t;

endpackage

// ---- tb_video_overlay_format_geometry.sv ----
// Self-checking bench for the overlay format and geometry block.
// Assumes the frame memory model as fetch partner.
`timescale 1ns/100ps
module tb_video_overlay_format_geometry;
    import overlay_fmt_pkg::*;
    localparam logic [31:0] KEY = 32'h5A5A0000;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
    logic [31:0] luma_base = '0, chroma_base = '0, fetched_word, pixel_word, s_axi_rdata;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, frame_start = 0, pixel_step = 0;
    logic [10:0] beam_x = '0, beam_y = '0;
    logic [1:0] mem_delay = '0, s_axi_bresp, s_axi_rresp;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic fetched_valid, fetch_busy, frame_fetched, in_window, pixel_valid;
    pixel_kind_t pixel_kind;
    geometry_t geometry;
    fetch_pos_t fetch_pos;
    int fails = 0, checks_done = 0, cycles = 0, pulses = 0;
    logic [31:0] ofs [7] = '{OFS_PIXEL_FORMAT, OFS_WINDOW_POS, OFS_WINDOW_SIZE,
        OFS_IMAGE_SIZE, OFS_ROW_STRIDE, OFS_PIXEL_STRIDE, OFS_CHROMA_STRIDE};
    logic [31:0] masks [7] = '{MASK_PIXEL_FORMAT, MASK_COORD_PAIR, MASK_COORD_PAIR,
        MASK_COORD_PAIR, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF};
    video_overlay_format_geometry i_dut (
        .*, .s_axi_awprot(3'h0), .s_axi_wstrb(4'hF), .s_axi_arprot(3'h0)
    );
    frame_memory_model i_mem (
        .aclk, .aresetn, .req(pixel_step), .addr(fetch_pos.luma_addr), .delay(mem_delay),
        .rd_word(fetched_word), .rd_valid(fetched_valid)
    );
    initial begin
        forever #5 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cycles++;
        if (frame_fetched === 1'b1) pulses++;
        if (cycles == 20000) begin
            fails++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic axi_write(input logic [31:0] a, input logic [31:0] d,
        input logic [1:0] er = RESP_OKAY);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                check(s_axi_bresp, er);
                s_axi_bready <= 1'b0;
                break;
            end
        end
        @(posedge aclk);
    endtask
    task automatic axi_read(input logic [31:0] a, input logic [31:0] exp,
        input logic [1:0] er = RESP_OKAY);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                check(s_axi_rdata, exp);
                check(s_axi_rresp, er);
                s_axi_rready <= 1'b0;
                break;
            end
        end
        @(posedge aclk);
    endtask
    task automatic frame(input logic [31:0] lb = '0, input logic [31:0] cb = '0);
        luma_base <= lb;
        chroma_base <= cb;
        frame_start <= 1'b1;
        @(posedge aclk);
        frame_start <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic step(input logic [31:0] word_exp);
        pixel_step <= 1'b1;
        @(posedge aclk);
        pixel_step <= 1'b0;
        for (int n = 0; n < 8 && pixel_valid !== 1'b1; n++) @(posedge aclk);
        check(pixel_word, word_exp);
        @(posedge aclk);
    endtask
    task automatic t_registers();
        for (int i = 0; i < 7; i++) axi_read(ofs[i], RESET_VALUE);
        for (int i = 0; i < 7; i++) begin
            axi_write(ofs[i], 32'hFFFFFFFF);
            axi_read(ofs[i], masks[i]);
        end
        axi_write(OFS_CHROMA_STRIDE + 32'h4, 32'h1, RESP_SLVERR);
        axi_read(OFS_CHROMA_STRIDE + 32'h4, 32'h0, RESP_SLVERR);
        check(geometry.width, 12'h1);
        check(pixel_kind.bad_code, 1'b0);
    endtask
    task automatic t_formats();
        byte rgb_bpp [14] = '{12, 16, 16, 16, 16, 18, 18, 19, 19, 24, 24, 25, 32, 32};
        byte yuv_bpp [9] = '{32, 16, 16, 16, 16, 16, 16, 12, 12};
        for (int i = 0; i < 16; i++) begin
            axi_write(OFS_PIXEL_FORMAT, {24'h0, i[3:0], 4'h0});
            frame();
            check(pixel_kind.bad_code, i > 13);
            if (i < 14) check(pixel_kind.bits_per_pixel, rgb_bpp[i]);
            check({pixel_kind.is_index, pixel_kind.is_yuv}, 2'h0);
        end
        for (int i = 0; i < 4; i++) begin
            axi_write(OFS_PIXEL_FORMAT, {22'h0, i[1:0], 8'h01});
            frame();
            check(pixel_kind.is_index, 1'b1);
            check(pixel_kind.bits_per_pixel, 1 << i);
        end
        for (int i = 0; i < 9; i++) begin
            axi_write(OFS_PIXEL_FORMAT, {16'h0, i[3:0], 12'h002});
            frame();
            check(pixel_kind.is_yuv, 1'b1);
            check(pixel_kind.bits_per_pixel, yuv_bpp[i]);
            check(pixel_kind.planes, i < 5 ? PLANES_ONE : (i[0] ? PLANES_SEMI : PLANES_THREE));
        end
        axi_write(OFS_PIXEL_FORMAT, 32'h31002);
        frame();
        check({pixel_kind.rotate_upsample, pixel_kind.luma_swap}, 2'h3);
    endtask
    task automatic t_walk();
        logic [31:0] lumas [4] = '{32'h1000, 32'h0FFC, 32'h1100, 32'h10FC};
        logic [31:0] chromas [4] = '{32'h8000, 32'h8000, 32'h8040, 32'h8040};
        axi_write(OFS_WINDOW_POS, 32'h20003);
        axi_write(OFS_WINDOW_SIZE, 32'h10004);
        axi_write(OFS_IMAGE_SIZE, 32'h10001);
        axi_write(OFS_ROW_STRIDE, 32'h100);
        axi_write(OFS_PIXEL_STRIDE, 32'hFFFFFFFC);
        axi_write(OFS_CHROMA_STRIDE, 32'h40);
        axi_write(OFS_PIXEL_FORMAT, 32'h5002);
        frame(32'h1000, 32'h8000);
        check({geometry.x_start, geometry.y_start}, {11'h3, 11'h2});
        check({geometry.width, geometry.height}, {12'h5, 12'h2});
        check({geometry.image_width, geometry.image_height}, 24'h002002);
        for (int k = 0; k < 4; k++) begin
            mem_delay <= k[1:0];
            step(lumas[k] ^ KEY);
            if (k < 3) begin
                check(fetch_pos.luma_addr, lumas[k+1]);
                check(fetch_pos.chroma_addr, chromas[k+1]);
                check({fetch_pos.column, fetch_pos.row}, {12'(!k[0]), 12'(k > 0)});
            end
        end
        repeat (3) @(posedge aclk);
        check(pulses, 1);
        check(fetch_busy, 1'b0);
    endtask
    task automatic t_window();
        int bx [6] = '{3, 2, 7, 8, 7, 5};
        int by [6] = '{2, 2, 3, 3, 4, 1};
        logic [5:0] hit = 6'h05;
        axi_write(OFS_WINDOW_POS, 32'h0);
        check(geometry.x_start, 11'h3);
        for (int i = 0; i < 6; i++) begin
            beam_x <= 11'(bx[i]);
            beam_y <= 11'(by[i]);
            repeat (2) @(posedge aclk);
            check(in_window, hit[i]);
        end
    endtask
    task automatic t_swap();
        logic [31:0] w;
        w = 32'h2000 ^ KEY;
        axi_write(OFS_PIXEL_FORMAT, 32'h21002);
        frame(32'h2000);
        step({w[31:24], w[7:0], w[15:8], w[23:16]});
    endtask
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_registers();
        t_formats();
        t_walk();
        t_window();
        t_swap();
        print_verdict();
    end
endmodule

// ---- video_overlay_format_geometry.sv ----
// Overlay layer format decode, window geometry and fetch address walk.
// Assumes frame_start, pixel_step and beam counters come from aclk logic.
`timescale 1ns/100ps

module video_overlay_format_geometry (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [overlay_fmt_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [overlay_fmt_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [overlay_fmt_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [overlay_fmt_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic frame_start,
    input wire logic [31:0] luma_base,
    input wire logic [31:0] chroma_base,
    input wire logic pixel_step,
    input wire logic [overlay_fmt_pkg::COORD_W-1:0] beam_x,
    input wire logic [overlay_fmt_pkg::COORD_W-1:0] beam_y,
    input wire logic [31:0] fetched_word,
    input wire logic fetched_valid,
    output overlay_fmt_pkg::pixel_kind_t pixel_kind,
    output overlay_fmt_pkg::geometry_t geometry,
    output overlay_fmt_pkg::fetch_pos_t fetch_pos,
    output logic fetch_busy,
    output logic frame_fetched,
    output logic in_window,
    output logic [31:0] pixel_word,
    output logic pixel_valid
);
    import overlay_fmt_pkg::*;

    // Software copies and the shadow set the layer really uses
    logic [31:0] cfg_r [0:6];
    logic [31:0] act_r [0:6];
    logic aw_held_r, w_held_r;
    logic [31:0] aw_addr_r, w_data_r;
    logic [3:0] w_strb_r;
    logic bvalid_r, rvalid_r;
    logic [1:0] bresp_r, rresp_r;
    logic [31:0] rdata_r;
    fetch_state_t state_r;
    fetch_pos_t pos_r;
    logic [31:0] luma_row_r, chroma_row_r;
    logic done_r;
    logic [31:0] word_r;
    logic word_valid_r;
    pixel_kind_t kind;
    geometry_t geo;

    // Register index of an address, 7 when unmapped
    function automatic logic [2:0] reg_index(input logic [31:0] a);
        if (a == OFS_PIXEL_FORMAT) begin
            return 3'd0;
        end else if (a == OFS_WINDOW_POS) begin
            return 3'd1;
        end else if (a == OFS_WINDOW_SIZE) begin
            return 3'd2;
        end else if (a == OFS_IMAGE_SIZE) begin
            return 3'd3;
        end else if (a == OFS_ROW_STRIDE) begin
            return 3'd4;
        end else if (a == OFS_PIXEL_STRIDE) begin
            return 3'd5;
        end else if (a == OFS_CHROMA_STRIDE) begin
            return 3'd6;
        end else begin
            return 3'd7;
        end
    endfunction

    function automatic logic [31:0] reg_mask(input logic [2:0] idx);
        if (idx == 3'd0) begin
            return MASK_PIXEL_FORMAT;
        end else if (idx < 3'd4) begin
            return MASK_COORD_PAIR;
        end else begin
            return 32'hFFFFFFFF;
        end
    endfunction

    // Write channel: address and data taken in either order
    assign s_axi_awready = !aw_held_r && !bvalid_r;
    assign s_axi_wready = !w_held_r && !bvalid_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            aw_addr_r <= RESET_VALUE;
            w_data_r <= RESET_VALUE;
            w_strb_r <= 4'h0;
        end else if (aw_held_r && w_held_r) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else if (aw_held_r && w_held_r) begin
            bvalid_r <= 1'b1;
            bresp_r <= (reg_index(aw_addr_r) == 3'd7 && aw_addr_r != OFS_STATUS) ?
                RESP_SLVERR : RESP_OKAY;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // Byte-lane writes into the software copies
    generate
        for (genvar g = 0; g < 7; g++) begin : g_cfg
            logic [31:0] wmask;
            assign wmask = reg_mask(3'(g));
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    cfg_r[g] <= RESET_VALUE;
                end else if (aw_held_r && w_held_r && reg_index(aw_addr_r) == 3'(g)) begin
                    for (int b = 0; b < 4; b++) begin
                        if (w_strb_r[b]) begin
                            cfg_r[g][8*b +: 8] <= w_data_r[8*b +: 8] & wmask[8*b +: 8];
                        end
                    end
                end
            end
            // Shadow copy so a frame never mixes settings
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    act_r[g] <= RESET_VALUE;
                end else if (frame_start) begin
                    act_r[g] <= cfg_r[g];
                end
            end
        end
    endgenerate

    // Read channel, one cycle after the address is taken
    assign s_axi_arready = !rvalid_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r <= RESET_VALUE;
            rresp_r <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_r <= 1'b1;
            rresp_r <= RESP_OKAY;
            if (s_axi_araddr == OFS_STATUS) begin
                rdata_r <= {done_r, fetch_busy, pixel_kind.bad_code, 5'h00,
                    pos_r.row, 4'h0, pos_r.column[7:0]};
            end else if (reg_index(s_axi_araddr) != 3'd7) begin
                rdata_r <= cfg_r[reg_index(s_axi_araddr)];
            end else begin
                rdata_r <= RESET_VALUE;
                rresp_r <= RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    // Format decode from the active set
    always_comb begin
        logic [3:0] rgb;
        logic [3:0] yuv;
        logic [1:0] depth;
        rgb = act_r[0][POS_RGB_FMT +: 4];
        yuv = act_r[0][POS_YUV_FMT +: 4];
        depth = act_r[0][POS_IDX_DEPTH +: 2];
        kind = '0;
        kind.is_index = act_r[0][POS_LUT_SEL];
        kind.is_yuv = act_r[0][POS_YUV_SEL];
        kind.rotate_upsample = kind.is_yuv && act_r[0][POS_ROT];
        kind.planes = PLANES_ONE;
        if (kind.is_yuv) begin
            kind.bits_per_pixel = 6'd16;
            if (yuv == YUV_AYCBCR_444) begin
                kind.bits_per_pixel = 6'd32;
                kind.has_alpha = 1'b1;
            end else if (yuv <= YUV_PACKED_LAST) begin
                kind.luma_swap = act_r[0][POS_SWAP];
            end else if (yuv <= YUV_420_PLANAR) begin
                // Chroma comes from its own plane
                kind.planes = (yuv == YUV_422_SEMI || yuv == YUV_420_SEMI) ?
                    PLANES_SEMI : PLANES_THREE;
                kind.chroma_half_rows = (yuv >= YUV_420_SEMI);
                kind.bits_per_pixel = kind.chroma_half_rows ? 6'd12 : 6'd16;
            end else begin
                kind.bad_code = 1'b1;
            end
        end else if (kind.is_index) begin
            kind.bits_per_pixel = 6'(6'd1 << depth);
        end else begin
            // Codes in listed order
            kind.packed_layout = (rgb == 4'h6 || rgb == 4'h8 || rgb == 4'hA);
            kind.has_alpha = (rgb == 4'h1 || rgb == 4'h2 || rgb == 4'h4 ||
                rgb == 4'h7 || rgb == 4'h8 || rgb >= RGB_1888_25);
            if (rgb == RGB_444_12) begin
                kind.bits_per_pixel = 6'd12;
            end else if (rgb < RGB_666_18) begin
                kind.bits_per_pixel = 6'd16;
            end else if (rgb < RGB_1666_19) begin
                kind.bits_per_pixel = 6'd18;
            end else if (rgb < RGB_888_24) begin
                kind.bits_per_pixel = 6'd19;
            end else if (rgb < RGB_1888_25) begin
                kind.bits_per_pixel = 6'd24;
            end else if (rgb == RGB_1888_25) begin
                kind.bits_per_pixel = 6'd25;
            end else if (rgb <= RGB_LAST) begin
                kind.bits_per_pixel = 6'd32;
            end else begin
                kind.bad_code = 1'b1;
            end
        end
    end

    // Geometry from the active set
    always_comb begin
        geo.x_start = act_r[1][POS_X +: COORD_W];
        geo.y_start = act_r[1][POS_Y +: COORD_W];
        geo.width = {1'b0, act_r[2][POS_X +: COORD_W]} + 12'd1;
        geo.height = {1'b0, act_r[2][POS_Y +: COORD_W]} + 12'd1;
        geo.image_width = {1'b0, act_r[3][POS_X +: COORD_W]} + 12'd1;
        geo.image_height = {1'b0, act_r[3][POS_Y +: COORD_W]} + 12'd1;
    end

    assign pixel_kind = kind;
    assign geometry = geo;

    // Window hit test; overflow past the line is software's job
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            in_window <= 1'b0;
        end else begin
            in_window <= ({1'b0, beam_x} >= {1'b0, geo.x_start}) &&
                ({1'b0, beam_x} < {1'b0, geo.x_start} + geo.width) &&
                ({1'b0, beam_y} >= {1'b0, geo.y_start}) &&
                ({1'b0, beam_y} < {1'b0, geo.y_start} + geo.height);
        end
    end

    // Fetch walk over the source image
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= FETCH_IDLE;
            pos_r <= '0;
            luma_row_r <= RESET_VALUE;
            chroma_row_r <= RESET_VALUE;
            done_r <= 1'b0;
        end else if (frame_start) begin
            // Bases taken with the new settings on the same edge
            state_r <= FETCH_RUN;
            pos_r.luma_addr <= luma_base;
            pos_r.chroma_addr <= chroma_base;
            pos_r.column <= '0;
            pos_r.row <= '0;
            luma_row_r <= luma_base;
            chroma_row_r <= chroma_base;
            done_r <= 1'b0;
        end else begin
            case (state_r)
                FETCH_RUN: begin
                    if (pixel_step) begin
                        if (pos_r.column + 12'd1 < geo.image_width) begin
                            pos_r.column <= pos_r.column + 12'd1;
                            // Signed offsets wrap in 32 bits
                            pos_r.luma_addr <= pos_r.luma_addr + act_r[5];
                        end else if (pos_r.row + 12'd1 < geo.image_height) begin
                            pos_r.column <= '0;
                            pos_r.row <= pos_r.row + 12'd1;
                            // Next row from the row start
                            pos_r.luma_addr <= luma_row_r + act_r[4];
                            luma_row_r <= luma_row_r + act_r[4];
                            // 420 chroma rows advance every second luma row
                            if (!kind.chroma_half_rows || pos_r.row[0]) begin
                                pos_r.chroma_addr <= chroma_row_r + act_r[6];
                                chroma_row_r <= chroma_row_r + act_r[6];
                            end
                        end else begin
                            state_r <= FETCH_DONE;
                            done_r <= 1'b1;
                        end
                    end
                end
                FETCH_DONE: begin
                    done_r <= 1'b0;
                    state_r <= FETCH_IDLE;
                end
                default: begin
                    state_r <= FETCH_IDLE;
                end
            endcase
        end
    end

    assign fetch_pos = pos_r;
    assign fetch_busy = (state_r == FETCH_RUN);
    assign frame_fetched = done_r;

    // Packed 422 luma swap; lanes follow the order code
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            word_r <= RESET_VALUE;
            word_valid_r <= 1'b0;
        end else begin
            word_valid_r <= fetched_valid;
            if (fetched_valid) begin
                word_r <= fetched_word;
                if (kind.luma_swap) begin
                    if (act_r[0][POS_YUV_FMT] == 1'b1) begin
                        word_r <= {fetched_word[31:24], fetched_word[7:0],
                            fetched_word[15:8], fetched_word[23:16]};
                    end else begin
                        word_r <= {fetched_word[15:8], fetched_word[23:16],
                            fetched_word[31:24], fetched_word[7:0]};
                    end
                end
            end
        end
    end

    assign pixel_word = word_r;
    assign pixel_valid = word_valid_r;

endmodule
